// ---- hw/sram_fe_consts.svh ----
// Constants for the synchronous burst static memory front end.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SRAM_FE_CONSTS_SVH
`define SRAM_FE_CONSTS_SVH

// Wide organisation: 512K words of 36 bits
`define SFE_WIDE_ADDR_W  19
`define SFE_WIDE_DATA_W  36
// Narrow organisation: 1M words of 18 bits
`define SFE_NARROW_ADDR_W 20
`define SFE_NARROW_DATA_W 18
// One write lane is a byte plus its parity bit
`define SFE_LANE_W       9
// Burst counter width and beats per burst
`define SFE_CNT_W        2
`define SFE_BURST_LEN    4
// Order select pin level for interleaved order
`define SFE_ORDER_INTERLEAVED 1'b1
// Flip-flops in the asynchronous-input synchroniser
`define SFE_SYNC_STAGES  2

`endif

// ---- hw/sram_fe_pkg.sv ----
// Types shared by the burst memory front end.
// Assumes the constants header sits beside it.
`include "sram_fe_consts.svh"

package sram_fe_pkg;

  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BURST,
    ST_SLEEP
  } access_state_t;

  // Low address bits of the burst counter
  typedef logic [`SFE_CNT_W-1:0] burst_low_t;

endpackage : sram_fe_pkg

// ---- hw/burst_counter.sv ----
// Two-bit burst address counter with interleaved or linear order.
// Assumes load and advance come from registered inputs on the same clock.
`include "sram_fe_consts.svh"

module burst_counter
  import sram_fe_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Control
  input  wire logic       load,
  input  wire logic       advance,
  input  wire logic       interleave,
  input  wire burst_low_t start_low,
  // Address of the current beat
  output burst_low_t      low_addr
);

  burst_low_t start_q, start_d;
  burst_low_t beat_q,  beat_d;

  // RULE5 load and increment
  assign start_d = load ? start_low : start_q;
  assign beat_d  = load ? '0 : (advance ? beat_q + 2'h1 : beat_q);

  // RULE11 order arithmetic; RULE7 order select
  assign low_addr = interleave ? (start_d ^ beat_d) : (start_d + beat_d);

  // Counter state; wraps after the fourth beat
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= '0;
      beat_q  <= '0;
    end else begin
      start_q <= start_d;
      beat_q  <= beat_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_count_step: assert property (advance && !load |=> beat_q == $past(beat_q) + 2'h1) // RULE5
    else $error("burst count did not step");
  a_count_hold: assert property (!advance && !load |=> beat_q == $past(beat_q)) // RULE6
    else $error("burst count moved without advance");
  a_order_xor: assert property (interleave |-> low_addr == (start_d ^ beat_d)) // RULE7
    else $error("interleaved address wrong");
  a_order_linear: assert property (!interleave && load |-> low_addr == start_low) // RULE11
    else $error("linear burst does not start at loaded address");

endmodule : burst_counter

// ---- hw/sync_burst_sram_front_end.sv ----
// Synchronous flow-through burst memory front end with flip-flop storage.
// Assumes the master is synchronous to clk_sys; oe_n and sleep_request are not.
// Operation
// RULE1: Register every synchronous input on the rising clock edge.
// RULE2: Output enable and sleep act independently of the access sequence.
// RULE3: Capture address and chip enables only while an address strobe is active.
// RULE4: Either address strobe starts a burst.
// RULE5: Load the start address into a two-bit counter and increment it.
// RULE6: Later burst addresses are generated inside, stepped only by advance.
// RULE7: Order pin high gives interleaved order, low gives linear order.
// RULE8: First beat takes two clocks, each following beat one clock.
// RULE9: Storage is 512K by 36 or 1M by 18 with common data lines.
// RULE10: Single-enable variant omits both depth-expansion enables.
// RULE11: Interleaved is start XOR beat; linear adds beat modulo four.
// RULE12: Writes complete internally once address, data and enables are registered.
`include "sram_fe_consts.svh"

module sync_burst_sram_front_end
  import sram_fe_pkg::*;
#(
  parameter int ADDR_W    = `SFE_WIDE_ADDR_W,
  parameter int DATA_W    = `SFE_WIDE_DATA_W,
  parameter bit SINGLE_CE = 1'b0
)(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Address and chip enables
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              pipelined_chip_enable_n,
  input  wire logic              depth_enable_hi,
  input  wire logic              depth_enable_lo_n,
  // Burst control
  input  wire logic              proc_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic              burst_order,
  // Write control
  input  wire logic [DATA_W/`SFE_LANE_W-1:0] byte_write_n,
  input  wire logic              byte_write_master_n,
  input  wire logic              global_write_n,
  // Asynchronous controls
  input  wire logic              oe_n,
  input  wire logic              sleep_request,
  // Common data lines, split into three signals
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  // Status
  output logic                   asleep
);

  localparam int LANES = DATA_W / `SFE_LANE_W;
  localparam int DEPTH = 2 ** ADDR_W;
  localparam int HI_W  = ADDR_W - `SFE_CNT_W;

  // Registered synchronous inputs
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              ce1_n_q, ce2_q, ce3_n_q;
  logic              proc_addr_strobe_n_n_q, ctrl_addr_strobe_n_n_q, adv_n_q, order_q;
  logic [LANES-1:0]  bw_n_q;
  logic              bwe_n_q, gw_n_q;

  // Synchroniser stages for the asynchronous controls
  logic              oe_n_s1_q, oe_n_s2_q;
  logic              sleep_s1_q, sleep_s2_q;

  // Sequencer and address state
  access_state_t     state_q, state_d;
  logic [HI_W-1:0]   base_q, base_d;
  burst_low_t        low_addr;
  logic [ADDR_W-1:0] eff_addr;

  // Storage and outputs
  wire  [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] dq_out_q;
  logic              dq_oe_q;
  logic              asleep_q;

  // Decode wires
  logic              start_hit;
  logic              sel_now;
  logic              access_now;
  logic [LANES-1:0]  lane_wr;
  logic              wr_fire;
  logic              rd_fire;
  logic              adv_now;

  // RULE1 input registers; one stage keeps the 2-1-1-1 timing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_q   <= '0;
      wdata_q  <= '0;
      ce1_n_q  <= 1'b1;
      ce2_q    <= 1'b0;
      ce3_n_q  <= 1'b1;
      proc_addr_strobe_n_n_q <= 1'b1;
      ctrl_addr_strobe_n_n_q <= 1'b1;
      adv_n_q  <= 1'b1;
      order_q  <= 1'b0;
      bw_n_q   <= '1;
      bwe_n_q  <= 1'b1;
      gw_n_q   <= 1'b1;
    end else begin
      addr_q   <= addr;
      wdata_q  <= dq_in;
      ce1_n_q  <= pipelined_chip_enable_n;
      ce2_q    <= depth_enable_hi;
      ce3_n_q  <= depth_enable_lo_n;
      proc_addr_strobe_n_n_q <= proc_addr_strobe_n;
      ctrl_addr_strobe_n_n_q <= ctrl_addr_strobe_n;
      adv_n_q  <= burst_advance_n;
      order_q  <= burst_order;
      bw_n_q   <= byte_write_n;
      bwe_n_q  <= byte_write_master_n;
      gw_n_q   <= global_write_n;
    end
  end

  // RULE2 async controls; two stages trade latency for metastability safety
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe_n_s1_q  <= 1'b1;
      oe_n_s2_q  <= 1'b1;
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      oe_n_s1_q  <= oe_n;
      oe_n_s2_q  <= oe_n_s1_q;
      sleep_s1_q <= sleep_request;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // RULE4 either strobe starts a burst
  assign start_hit = !proc_addr_strobe_n_n_q || !ctrl_addr_strobe_n_n_q;

  // RULE10 single-enable variant ignores depth enables
  assign sel_now = SINGLE_CE ? !ce1_n_q : (!ce1_n_q && ce2_q && !ce3_n_q);

  // Sequencer next state; sleep blocks any new access
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE, ST_BURST: begin
        if (sleep_s2_q) begin
          state_d = ST_SLEEP;
        end else if (start_hit) begin
          state_d = sel_now ? ST_BURST : ST_IDLE;
        end
      end
      ST_SLEEP: begin
        // A strobe in the waking cycle is not lost
        if (!sleep_s2_q) begin
          state_d = (start_hit && sel_now) ? ST_BURST : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign access_now = (state_d == ST_BURST);

  // RULE3 address captured only under a strobe
  assign base_d   = start_hit ? addr_q[ADDR_W-1:`SFE_CNT_W] : base_q;
  assign eff_addr = {base_d, low_addr};

  // RULE6 advance steps the counter only inside a running burst
  assign adv_now = access_now && !start_hit && !adv_n_q;

  // Global write beats lane writes; master enable gates lane writes
  assign lane_wr = !gw_n_q ? '1 : (!bwe_n_q ? ~bw_n_q : '0);

  // A processor-strobe start is always a read; its write follows later
  assign wr_fire = access_now && (|lane_wr) && proc_addr_strobe_n_n_q;
  assign rd_fire = access_now && !wr_fire;

  // RULE5 counter instance, loaded at every strobe
  burst_counter u_cnt (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .load       (start_hit),
    .advance    (adv_now),
    .interleave (order_q == `SFE_ORDER_INTERLEAVED),
    .start_low  (addr_q[`SFE_CNT_W-1:0]),
    .low_addr   (low_addr)
  );

  // Sequencer and base address registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      base_q  <= '0;
    end else begin
      state_q <= state_d;
      base_q  <= base_d;
    end
  end

  // RULE12 self-timed lane writes; RULE9 storage, no reset on the array
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // One array per lane keeps a single writer on each
    logic [`SFE_LANE_W-1:0] lane_mem_q [DEPTH];
    always_ff @(posedge clk_sys) begin
      if (wr_fire && lane_wr[g]) begin
        lane_mem_q[eff_addr] <= wdata_q[g*`SFE_LANE_W +: `SFE_LANE_W];
      end
    end
    assign rd_word[g*`SFE_LANE_W +: `SFE_LANE_W] = lane_mem_q[eff_addr];
  end

  // RULE8 read data one edge after the registered request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dq_out_q <= '0;
      dq_oe_q  <= 1'b0;
      asleep_q <= 1'b0;
    end else begin
      if (rd_fire) begin
        dq_out_q <= rd_word;
      end
      dq_oe_q  <= rd_fire && !oe_n_s2_q;
      asleep_q <= (state_d == ST_SLEEP);
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe  = dq_oe_q;
  assign asleep = asleep_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_start_sel;
    start_hit && sel_now && !sleep_s2_q;
  endsequence

  sequence s_read_beat;
    rd_fire;
  endsequence

  a_input_capture: assert property (1'b1 |=> addr_q == $past(addr) && ctrl_addr_strobe_n_n_q == $past(ctrl_addr_strobe_n)) // RULE1
    else $error("synchronous input not registered");
  a_oe_blocks: assert property (oe_n_s2_q |=> !dq_oe_q) // RULE2
    else $error("data driven while output disabled");
  a_addr_held: assert property (!start_hit |=> base_q == $past(base_q)) // RULE3
    else $error("address captured without a strobe");
  a_strobe_start: assert property (s_start_sel |=> state_q == ST_BURST) // RULE4
    else $error("strobe did not start a burst");
  a_first_beat: assert property (s_read_beat |=> dq_out_q == $past(rd_word)) // RULE8
    else $error("read beat data wrong");
  a_read_drive: assert property (s_read_beat and !oe_n_s2_q |=> dq_oe_q) // RULE8
    else $error("read beat not driven");
  a_sleep_idle: assert property (sleep_s2_q |=> !dq_oe_q && state_q == ST_SLEEP) // RULE2
    else $error("sleep did not stop access");
  a_write_lane: assert property (wr_fire && lane_wr[0] |=>
    g_lane[0].lane_mem_q[$past(eff_addr)] == $past(wdata_q[`SFE_LANE_W-1:0])) // RULE12
    else $error("write did not land");

endmodule : sync_burst_sram_front_end

// ---- verif/burst_master_model.sv ----
// Master model: a processor or cache controller running burst memory cycles.
// Assumes the bench calls its tasks; every pin changes on a falling edge.
module burst_master_model #(
  parameter int AW = 6,
  parameter int DW = 36
)(
  // Clock and read data
  input  wire logic          clk_sys,
  input  wire logic [DW-1:0] dq_out,
  input  wire logic          dq_oe,
  // Memory control
  output logic [AW-1:0] addr,
  output logic          ce_n,
  output logic          proc_n,
  output logic          ctrl_n,
  output logic          adv_n,
  output logic          order,
  output logic [3:0]    bw_n,
  output logic          bwm_n,
  output logic          gw_n,
  output logic [DW-1:0] dq_in
);
  // Idle levels from time zero
  initial begin
    addr   = '0;
    ce_n   = 1'b0;
    proc_n = 1'b1;
    ctrl_n = 1'b1;
    adv_n  = 1'b1;
    order  = 1'b0;
    bw_n   = 4'hf;
    bwm_n  = 1'b1;
    gw_n   = 1'b1;
    dq_in  = '0;
  end

  // Read burst; records data and enable after each beat edge
  task automatic read_burst(input logic [AW-1:0] a, input logic ord, input logic sel,
                            output logic [DW-1:0] d [4], output logic [3:0] oe);
    @(negedge clk_sys);
    addr   = a;
    order  = ord;
    ce_n   = ~sel;
    proc_n = 1'b0;
    @(negedge clk_sys);
    proc_n = 1'b1;
    addr   = ~a;  // No longer qualified, so it wanders
    adv_n  = 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_sys);
      d[k]  = dq_out;
      oe[k] = dq_oe;
      if (k == 2)
        adv_n = 1'b1;
    end
    ce_n = 1'b0;
  endtask : read_burst

  // Linear write burst; lanes_n of zero means a global write
  task automatic write_burst(input logic [AW-1:0] a, input int n, input logic [3:0] lanes_n,
                             input logic [DW-1:0] d [4]);
    @(negedge clk_sys);
    addr   = a;
    order  = 1'b0;
    ctrl_n = 1'b0;
    bw_n   = lanes_n;
    gw_n   = (lanes_n != 4'h0);
    bwm_n  = (lanes_n == 4'h0);
    for (int k = 0; k < n; k++) begin
      dq_in = d[k];
      @(negedge clk_sys);
      ctrl_n = 1'b1;
      adv_n  = (k == n - 1);
    end
    gw_n  = 1'b1;
    bwm_n = 1'b1;
    bw_n  = 4'hf;
    dq_in = ~dq_in;  // Released data never holds its value
  endtask : write_burst
endmodule : burst_master_model

// ---- verif/sync_burst_sram_front_end_tb.sv ----
// Bench for the burst memory front end, driven through the master model.
// Assumes a 6-bit address build with the default 36-bit data width.
module sync_burst_sram_front_end_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 6;
  localparam int DW = 36;
  logic          clk_sys = 1'b0;
  logic          arst_n = 1'b0;
  logic          oe_n = 1'b0;
  logic          sleep_request = 1'b0;
  logic          depth_hi = 1'b1;
  logic [AW-1:0] addr;
  logic          ce_n, proc_n, ctrl_n, adv_n, order, bwm_n, gw_n, dq_oe, asleep;
  logic [3:0]    bw_n;
  logic [DW-1:0] dq_in, dq_out;
  logic [DW-1:0] wd [4];
  int            fails, samples_checked, cycles;

  burst_master_model #(.AW(AW), .DW(DW)) mst (.clk_sys, .dq_out, .dq_oe, .addr, .ce_n,
    .proc_n, .ctrl_n, .adv_n, .order, .bw_n, .bwm_n, .gw_n, .dq_in);
  // Low depth enable held active; the high one is driven by the refusal scenario
  sync_burst_sram_front_end #(.ADDR_W(AW)) dut (.clk_sys, .arst_n, .addr,
    .pipelined_chip_enable_n(ce_n), .depth_enable_hi(depth_hi), .depth_enable_lo_n(1'b0),
    .proc_addr_strobe_n(proc_n), .ctrl_addr_strobe_n(ctrl_n), .burst_advance_n(adv_n),
    .burst_order(order), .byte_write_n(bw_n), .byte_write_master_n(bwm_n),
    .global_write_n(gw_n), .oe_n, .sleep_request, .dq_in, .dq_out, .dq_oe, .asleep);

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Hang guard; the run needs about 80 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fails++;
      close_out();
    end
  end

  // One burst read, judged against the expected beat order
  task automatic read_check(input logic [AW-1:0] a, input logic ord, input logic sel,
                            input logic oe_exp, input logic chk);
    logic [DW-1:0] got [4];
    logic [3:0]    oe;
    logic [1:0]    idx;
    mst.read_burst(a, ord, sel, got, oe);
    for (int k = 0; k < 4; k++) begin
      idx = ord ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
      check("beat enable", DW'(oe[k]), DW'(oe_exp));
      if (chk)
        check("beat data", got[k], wd[idx]);
    end
  endtask : read_check

  task automatic t_bursts;
    logic [DW-1:0] ones [4];
    ones = '{default: '1};
    wd = '{36'h0_1111_1111, 36'h2_2222_2222, 36'h4_4444_4444, 36'h8_8888_8888};
    mst.write_burst(6'h10, 4, 4'h0, wd);
    read_check(6'h11, 1'b1, 1'b1, 1'b1, 1'b1);
    read_check(6'h12, 1'b0, 1'b1, 1'b1, 1'b1);
    // Lane zero only, through the byte-write master enable
    mst.write_burst(6'h10, 1, 4'he, ones);
    wd[0][8:0] = 9'h1ff;
    read_check(6'h10, 1'b0, 1'b1, 1'b1, 1'b1);
  endtask : t_bursts

  // Deselected strobe gives no access, next start works back to back
  task automatic t_refused;
    read_check(6'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    // Depth enable low also deselects a strobe
    depth_hi = 1'b0;
    read_check(6'h12, 1'b0, 1'b1, 1'b0, 1'b0);
    depth_hi = 1'b1;
    read_check(6'h13, 1'b1, 1'b1, 1'b1, 1'b1);
  endtask : t_refused

  // Output enable off: no drive, data still updates
  task automatic t_oe;
    oe_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    read_check(6'h11, 1'b0, 1'b1, 1'b0, 1'b1);
    oe_n = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : t_oe

  task automatic t_sleep;
    sleep_request = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("asleep", DW'(asleep), DW'(1'b1));
    read_check(6'h10, 1'b0, 1'b1, 1'b0, 1'b0);
    sleep_request = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("awake", DW'(asleep), DW'(1'b0));
    read_check(6'h10, 1'b0, 1'b1, 1'b1, 1'b1);
  endtask : t_sleep

  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    t_bursts();
    t_refused();
    t_oe();
    t_sleep();
    close_out();
  end
endmodule : sync_burst_sram_front_end_tb
